// ==== core/acr_pkg.sv ====
// Package: register map, reset values and carriers of the audio clock ratio control
package acr_pkg;

    // ********************************************
    // Register indices (byte address = 4 * index)
    // ********************************************
    localparam logic [9:0] IDX_CTRL     = 10'h031;
    localparam logic [9:0] IDX_RATE     = 10'h032;
    localparam logic [9:0] IDX_NUMER_LO = 10'h033;
    localparam logic [9:0] IDX_NUMER_HI = 10'h034;
    localparam logic [9:0] IDX_DENOM_LO = 10'h035;
    localparam logic [9:0] IDX_DENOM_HI = 10'h036;
    localparam logic [9:0] IDX_LOOP_CAP = 10'h039;
    localparam logic [9:0] IDX_LOOP_RES = 10'h03a;
    localparam logic [9:0] IDX_STATUS   = 10'h020;

    // ********************************************
    // Control register fields
    // ********************************************
    localparam int CTRL_REF_OFF_BIT = 0;
    localparam int CTRL_STRETCH_BIT = 1;
    localparam int CTRL_HOST_SEL_BIT = 2;
    localparam int CTRL_UPDATE_BIT  = 6;
    // Writable bits: 9..5 and 2..0, the rest reserved
    localparam logic [15:0] CTRL_RW_MASK = 16'h03e7;
    localparam logic [15:0] CTRL_RESET   = 16'h0100;

    // ********************************************
    // Other field widths and reset values
    // ********************************************
    localparam int RATE_W = 3;
    localparam int LOOP_W = 6;
    localparam logic [2:0] RATE_RESET = 3'h3;

    // ********************************************
    // Carriers
    // ********************************************
    typedef struct packed {
        logic [31:0] numer;
        logic [31:0] denom;
    } acr_ratio_s;

    typedef struct packed {
        logic [5:0] cap;
        logic [5:0] res;
    } acr_loop_s;

endpackage

// ==== core/acr_audio_clock_ratio_control.sv ====
// Audio clock ratio control: APB registers, rate selection, ratio update, frame sync pulse
//
// Function
// - Host rate select high takes rate from register; low uses the pins.
// - Field stretch set lengthens frame sync pulse from one line to one field.
// - Reference reset off: field-id input stops resetting the pulse; host reset remains.
// - Sample rate register resets to 011, which means 48 kHz.
// - Non-zero 32-bit numerator sets audio clock to reference ratio numerator.
// - Non-zero 32-bit denominator sets audio clock to reference ratio denominator.
// - Numerator low half at 33h, high half at 34h.
// - Denominator low half at 35h, high half at 36h.
// - Ratio loads only on rising update bit, and only non-zero values.
// - Ratio reset contents follow the currently selected audio rate.
// - Loop setting defaults follow the currently selected sampling rate.
//
// Our own choice: the APB slave port.
`timescale 1ns/10ps
module acr_audio_clock_ratio_control #(
    parameter int          ADDR_W      = 12,
    parameter int          SYNC_FIELDS = 5,
    parameter logic [255:0] NUMER_DFLT = {8{32'h0000_0200}},
    parameter logic [255:0] DENOM_DFLT = {8{32'h0000_0200}},
    parameter logic [47:0]  CAP_DFLT   = {8{6'h0c}},
    parameter logic [47:0]  RES_DFLT   = {8{6'h24}}
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [2:0]        rate_pins,
    input  wire logic              ref_field_id_in,
    input  wire logic              line_start,
    input  wire logic              field_start,
    input  wire logic              host_frame_reset,
    output logic [2:0]             sample_rate_sel,
    output acr_pkg::acr_ratio_s    ratio_out,
    output acr_pkg::acr_loop_s     loop_out,
    output logic [15:0]            ctrl_out,
    output logic                   audio_frame_sync
);

    // ********************************************
    // State
    // ********************************************
    logic [15:0] ctrl_r;
    logic [2:0]  rate_r;
    logic [31:0] numer_r;
    logic [31:0] denom_r;
    logic        numer_wr_r;
    logic        denom_wr_r;
    logic [31:0] numer_app_r;
    logic [31:0] denom_app_r;
    logic        numer_cus_r;
    logic        denom_cus_r;
    logic [5:0]  cap_r;
    logic [5:0]  res_r;
    logic        cap_wr_r;
    logic        res_wr_r;
    logic        upd_prev_r;
    logic [2:0]  pin_s1_r;
    logic [2:0]  pin_s2_r;
    logic [2:0]  pin_s3_r;
    logic [2:0]  pin_rate_r;
    logic        fid_s1_r;
    logic        fid_s2_r;
    logic        fid_s3_r;
    logic        fid_r;
    logic [7:0]  fld_cnt_r;
    logic [7:0]  fld_cnt_nxt;
    logic        pulse_r;
    logic        pulse_nxt;
    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;
    logic [2:0]  rate_out_r;
    acr_pkg::acr_ratio_s ratio_r;
    acr_pkg::acr_loop_s  loop_r;

    // ********************************************
    // Bus decode
    // ********************************************
    // Access phase is two cycles: pready is a flop, so it rises one edge late
    wire       acc     = psel & penable;
    wire       done    = acc & pready_r;
    wire [9:0] idx     = paddr[11:2];
    wire       wr      = done & pwrite;
    wire       hit_ctrl = (idx == acr_pkg::IDX_CTRL);
    wire       hit_rate = (idx == acr_pkg::IDX_RATE);
    wire       hit_nlo  = (idx == acr_pkg::IDX_NUMER_LO);
    wire       hit_nhi  = (idx == acr_pkg::IDX_NUMER_HI);
    wire       hit_dlo  = (idx == acr_pkg::IDX_DENOM_LO);
    wire       hit_dhi  = (idx == acr_pkg::IDX_DENOM_HI);
    wire       hit_cap  = (idx == acr_pkg::IDX_LOOP_CAP);
    wire       hit_res  = (idx == acr_pkg::IDX_LOOP_RES);
    wire       hit_stat = (idx == acr_pkg::IDX_STATUS);
    wire       mapped   = hit_ctrl | hit_rate | hit_nlo | hit_nhi | hit_dlo
                        | hit_dhi | hit_cap | hit_res | hit_stat;
    wire [15:0] wd      = pwdata[15:0];

    // ********************************************
    // Effective rate and rate-dependent defaults
    // ********************************************
    wire        host_sel = ctrl_r[acr_pkg::CTRL_HOST_SEL_BIT];
    wire [2:0]  eff_rate = host_sel ? rate_r : pin_rate_r;
    wire [31:0] numer_def = NUMER_DFLT[eff_rate*32 +: 32];
    wire [31:0] denom_def = DENOM_DFLT[eff_rate*32 +: 32];
    wire [5:0]  cap_def   = CAP_DFLT[eff_rate*6 +: 6];
    wire [5:0]  res_def   = RES_DFLT[eff_rate*6 +: 6];
    // Until written, staged values read back as the rate default
    wire [31:0] numer_rd = numer_wr_r ? numer_r : numer_def;
    wire [31:0] denom_rd = denom_wr_r ? denom_r : denom_def;
    wire [5:0]  cap_rd   = cap_wr_r ? cap_r : cap_def;
    wire [5:0]  res_rd   = res_wr_r ? res_r : res_def;

    // ********************************************
    // Update edge
    // ********************************************
    wire upd_bit  = ctrl_r[acr_pkg::CTRL_UPDATE_BIT];
    wire upd_edge = upd_bit & ~upd_prev_r;
    wire numer_ld = upd_edge & (numer_rd != 32'h0000_0000);
    wire denom_ld = upd_edge & (denom_rd != 32'h0000_0000);

    // ********************************************
    // Read mux, reserved bits zero
    // ********************************************
    wire [31:0] rd_data =
        hit_ctrl ? {16'h0000, ctrl_r}                    :
        hit_rate ? {29'h0000_0000, rate_r}               :
        hit_nlo  ? {16'h0000, numer_rd[15:0]}            :
        hit_nhi  ? {16'h0000, numer_rd[31:16]}           :
        hit_dlo  ? {16'h0000, denom_rd[15:0]}            :
        hit_dhi  ? {16'h0000, denom_rd[31:16]}           :
        hit_cap  ? {26'h000_0000, cap_rd}                :
        hit_res  ? {26'h000_0000, res_rd}                :
        hit_stat ? {24'h00_0000, audio_frame_sync, denom_cus_r, numer_cus_r,
                    host_sel, 1'b0, eff_rate}             :
                   32'h0000_0000;

    // ********************************************
    // Frame sync pulse next state
    // ********************************************
    // Reference reset acts on the filtered rising edge of the field-id pin
    wire ref_off   = ctrl_r[acr_pkg::CTRL_REF_OFF_BIT];
    wire fid_rise  = (fid_s2_r == fid_s3_r) & fid_s3_r & ~fid_r;
    wire ref_rst   = fid_rise & ~ref_off;
    wire wrap      = field_start & (fld_cnt_r == 8'(SYNC_FIELDS - 1));
    wire start     = ref_rst | host_frame_reset | wrap;
    wire stretch   = ctrl_r[acr_pkg::CTRL_STRETCH_BIT];
    wire pulse_end = stretch ? field_start : line_start;

    always_comb begin
        fld_cnt_nxt = fld_cnt_r;
        pulse_nxt   = pulse_r;
        if (start) begin
            fld_cnt_nxt = 8'h00;
            pulse_nxt   = 1'b1;
        end else begin
            if (field_start) begin
                fld_cnt_nxt = fld_cnt_r + 8'h01;
            end
            if (pulse_end) begin
                pulse_nxt = 1'b0;
            end
        end
    end

    // ********************************************
    // APB handshake and read data
    // ********************************************
    // Unmapped word answers with pslverr and zero data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= acc & ~pready_r;
            prdata_r  <= (acc & ~pready_r & ~pwrite) ? rd_data : 32'h0000_0000;
            pslverr_r <= acc & ~pready_r & ~mapped;
        end
    end

    // ********************************************
    // Control and rate registers
    // ********************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r     <= acr_pkg::CTRL_RESET;
            rate_r     <= acr_pkg::RATE_RESET;
            upd_prev_r <= 1'b0;
        end else begin
            upd_prev_r <= upd_bit;
            if (wr & hit_ctrl) begin
                ctrl_r <= wd & acr_pkg::CTRL_RW_MASK;
            end
            if (wr & hit_rate) begin
                rate_r <= wd[2:0];
            end
        end
    end

    // ********************************************
    // Staged ratio halves
    // ********************************************
    // Halves are staged only; the synthesiser never sees a half-written value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            numer_r    <= 32'h0000_0000;
            denom_r    <= 32'h0000_0000;
            numer_wr_r <= 1'b0;
            denom_wr_r <= 1'b0;
        end else begin
            if (wr & (hit_nlo | hit_nhi)) begin
                numer_wr_r <= 1'b1;
                numer_r    <= hit_nlo ? {numer_rd[31:16], wd} : {wd, numer_rd[15:0]};
            end
            if (wr & (hit_dlo | hit_dhi)) begin
                denom_wr_r <= 1'b1;
                denom_r    <= hit_dlo ? {denom_rd[31:16], wd} : {wd, denom_rd[15:0]};
            end
        end
    end

    // ********************************************
    // Applied ratio
    // ********************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            numer_app_r <= 32'h0000_0000;
            denom_app_r <= 32'h0000_0000;
            numer_cus_r <= 1'b0;
            denom_cus_r <= 1'b0;
        end else begin
            if (numer_ld) begin
                numer_app_r <= numer_rd;
                numer_cus_r <= 1'b1;
            end
            if (denom_ld) begin
                denom_app_r <= denom_rd;
                denom_cus_r <= 1'b1;
            end
        end
    end

    // ********************************************
    // Loop bandwidth settings
    // ********************************************
    // Range limits are left to software; values are stored as written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_r    <= 6'h00;
            res_r    <= 6'h00;
            cap_wr_r <= 1'b0;
            res_wr_r <= 1'b0;
        end else begin
            if (wr & hit_cap) begin
                cap_r    <= wd[5:0];
                cap_wr_r <= 1'b1;
            end
            if (wr & hit_res) begin
                res_r    <= wd[5:0];
                res_wr_r <= 1'b1;
            end
        end
    end

    // ********************************************
    // Pin synchronisers
    // ********************************************
    // Three stages; a change counts only when stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_r   <= 3'h0;
            pin_s2_r   <= 3'h0;
            pin_s3_r   <= 3'h0;
            pin_rate_r <= acr_pkg::RATE_RESET;
            fid_s1_r   <= 1'b0;
            fid_s2_r   <= 1'b0;
            fid_s3_r   <= 1'b0;
            fid_r      <= 1'b0;
        end else begin
            pin_s1_r <= rate_pins;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            fid_s1_r <= ref_field_id_in;
            fid_s2_r <= fid_s1_r;
            fid_s3_r <= fid_s2_r;
            if (pin_s2_r == pin_s3_r) begin
                pin_rate_r <= pin_s3_r;
            end
            if (fid_s2_r == fid_s3_r) begin
                fid_r <= fid_s3_r;
            end
        end
    end

    // ********************************************
    // Frame sync pulse and output registers
    // ********************************************
    // Ratio outputs: rate default until a custom value has been loaded
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fld_cnt_r  <= 8'h00;
            pulse_r    <= 1'b0;
            rate_out_r <= acr_pkg::RATE_RESET;
            ratio_r    <= '0;
            loop_r     <= '0;
        end else begin
            fld_cnt_r     <= fld_cnt_nxt;
            pulse_r       <= pulse_nxt;
            rate_out_r    <= eff_rate;
            ratio_r.numer <= numer_cus_r ? numer_app_r : numer_def;
            ratio_r.denom <= denom_cus_r ? denom_app_r : denom_def;
            loop_r.cap    <= cap_rd;
            loop_r.res    <= res_rd;
        end
    end

    // ********************************************
    // Port drive
    // ********************************************
    assign prdata           = prdata_r;
    assign pready           = pready_r;
    assign pslverr          = pslverr_r;
    assign sample_rate_sel  = rate_out_r;
    assign ratio_out        = ratio_r;
    assign loop_out         = loop_r;
    assign ctrl_out         = ctrl_r;
    assign audio_frame_sync = pulse_r;

endmodule // acr_audio_clock_ratio_control

// ==== sim/acr_ratio_ctrl_props.sv ====
// Checker: concurrent properties on the ports of the audio clock ratio control
`timescale 1ns/10ps
module acr_ratio_ctrl_props #(
    parameter int ADDR_W = 12
) (
    input wire logic                pclk,
    input wire logic                presetn,
    input wire logic [ADDR_W-1:0]   paddr,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [31:0]         pwdata,
    input wire logic [31:0]         prdata,
    input wire logic                pready,
    input wire logic                pslverr,
    input wire logic [2:0]          rate_pins,
    input wire logic                ref_field_id_in,
    input wire logic                line_start,
    input wire logic                field_start,
    input wire logic                host_frame_reset,
    input wire logic [2:0]          sample_rate_sel,
    input wire acr_pkg::acr_ratio_s ratio_out,
    input wire acr_pkg::acr_loop_s  loop_out,
    input wire logic [15:0]         ctrl_out,
    input wire logic                audio_frame_sync
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ****************
    // Cycles since the update bit rose; reset counts as a fresh load window
    // ****************
    logic [2:0] since_upd_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) since_upd_r <= 3'h0;
        else if ($rose(ctrl_out[acr_pkg::CTRL_UPDATE_BIT])) since_upd_r <= 3'h0;
        else if (since_upd_r != 3'h7) since_upd_r <= since_upd_r + 3'h1;
    end
    // ****************
    // Properties
    // ****************
    property p_rate_pins;
        (!ctrl_out[acr_pkg::CTRL_HOST_SEL_BIT] && $stable(rate_pins)) [*7] |-> sample_rate_sel == rate_pins;
    endproperty
    a_rate_pins: assert property (p_rate_pins) else $error("rate not taken from pins");
    property p_host_start;
        host_frame_reset |-> ##[1:2] audio_frame_sync;
    endproperty
    a_host_start: assert property (p_host_start) else $error("host reset did not start sync");
    property p_line_end;
        audio_frame_sync && line_start && !ctrl_out[1] && !host_frame_reset && !field_start
            |=> ##[0:1] !audio_frame_sync;
    endproperty
    a_line_end: assert property (p_line_end) else $error("sync outlived its line");
    property p_stretch_hold;
        ctrl_out[1] && audio_frame_sync && !field_start && !$past(field_start) |=> audio_frame_sync;
    endproperty
    a_stretch_hold: assert property (p_stretch_hold) else $error("stretched sync ended early");
    property p_ref_off;
        ctrl_out[0] [*6] ##0 (!audio_frame_sync && !host_frame_reset && !field_start && !$past(field_start))
            |=> !audio_frame_sync;
    endproperty
    a_ref_off: assert property (p_ref_off) else $error("sync started with ref reset off");
    property p_ratio_hold;
        $changed(ratio_out) |-> since_upd_r <= 3'h3;
    endproperty
    a_ratio_hold: assert property (p_ratio_hold) else $error("ratio changed without update");
    property p_ratio_nonzero;
        $changed(ratio_out) |-> ratio_out.numer != 32'h0 && ratio_out.denom != 32'h0;
    endproperty
    a_ratio_nonzero: assert property (p_ratio_nonzero) else $error("zero ratio applied");
    property p_ctrl_rsvd;
        pready && !pwrite && paddr[ADDR_W-1:2] == acr_pkg::IDX_CTRL |-> (prdata & ~32'h0000_03e7) == 32'h0;
    endproperty
    a_ctrl_rsvd: assert property (p_ctrl_rsvd) else $error("reserved control bits read non-zero");
    property p_apb_wait;
        psel && !penable |=> !pready ##1 pready;
    endproperty
    a_apb_wait: assert property (p_apb_wait) else $error("ready not on second access cycle");
    c_host_sel: cover property (ctrl_out[acr_pkg::CTRL_HOST_SEL_BIT] && sample_rate_sel == 3'h6);
    c_stretch: cover property (ctrl_out[1] && audio_frame_sync && line_start);
    c_ratio: cover property ($changed(ratio_out) && since_upd_r <= 3'h3);
endmodule // acr_ratio_ctrl_props

bind acr_audio_clock_ratio_control acr_ratio_ctrl_props #(.ADDR_W(ADDR_W)) u_props (.pclk(pclk),
    .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rate_pins(rate_pins),
    .ref_field_id_in(ref_field_id_in), .line_start(line_start), .field_start(field_start),
    .host_frame_reset(host_frame_reset), .sample_rate_sel(sample_rate_sel), .ratio_out(ratio_out),
    .loop_out(loop_out), .ctrl_out(ctrl_out), .audio_frame_sync(audio_frame_sync));

// ==== sim/acr_host_model.sv ====
// Host model: APB master issuing register transfers with a bounded wait for pready
`timescale 1ns/10ps
module acr_host_model (
    input  wire logic        pclk,
    output logic [11:0]      paddr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             tmo
);
    // ****************
    // Idle bus at time zero
    // ****************
    initial begin
        paddr = 12'h000;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h0;
        tmo = 1'b0;
    end
    // One transfer; request held until pready is sampled high at a rising edge
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        q = prdata;
        e = pslverr;
        if (pready !== 1'b1) tmo = 1'b1;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines turn over so stale values never look valid
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule // acr_host_model

// ==== sim/audio_clock_ratio_control_tb.sv ====
// Testbench: registers, rate source, ratio update and frame sync of the audio clock ratio control
`timescale 1ns/10ps
module audio_clock_ratio_control_tb;
    logic                pclk;
    logic                presetn;
    logic [11:0]         paddr;
    logic                psel, penable, pwrite, pready, pslverr, tmo, ref_field_id_in, sync;
    logic [31:0]         pwdata, prdata, rdat;
    logic                rerr;
    logic [2:0]          pins, sample_rate_sel, strobes;
    logic [15:0]         ctrl;
    acr_pkg::acr_ratio_s ratio;
    acr_pkg::acr_loop_s  loop;
    int                  fails, comparisons;
    logic [9:0]          ridx [7] = '{acr_pkg::IDX_CTRL, acr_pkg::IDX_RATE, acr_pkg::IDX_NUMER_LO,
                             acr_pkg::IDX_NUMER_HI, acr_pkg::IDX_DENOM_LO, acr_pkg::IDX_LOOP_CAP,
                             acr_pkg::IDX_LOOP_RES};
    logic [31:0]         rexp [7] = '{32'h0100, 32'h3, 32'h200, 32'h0, 32'h200, 32'h0c, 32'h24};

    acr_host_model host (.pclk(pclk), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tmo(tmo));
    // Short free-run count keeps the field sequence brief
    acr_audio_clock_ratio_control #(.SYNC_FIELDS(4)) uut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rate_pins(pins), .ref_field_id_in(ref_field_id_in), .line_start(strobes[0]),
        .field_start(strobes[1]), .host_frame_reset(strobes[2]), .sample_rate_sel(sample_rate_sel),
        .ratio_out(ratio), .loop_out(loop), .ctrl_out(ctrl), .audio_frame_sync(sync));

    // ****************
    // Helpers
    // ****************
    task automatic wrap_up();
        if (tmo) fails = fails + 1;
        $display("comparisons %0d, mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    task automatic wr(input logic [9:0] idx, input logic [31:0] d);
        host.xfer({idx, 2'b00}, 1'b1, d, rdat, rerr);
        if (tmo) wrap_up();
    endtask
    task automatic rd(input logic [9:0] idx, input logic [31:0] exp, input logic exp_err);
        host.xfer({idx, 2'b00}, 1'b0, 32'h0, rdat, rerr);
        if (tmo) wrap_up();
        chk(rdat, exp);
        chk(rerr, exp_err);
    endtask
    // One-cycle timing strobe, then let the pulse logic settle
    task automatic strobe(input logic [2:0] v);
        @(posedge pclk);
        strobes <= v;
        @(posedge pclk);
        strobes <= 3'h0;
        tick(3);
    endtask

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    initial begin
        presetn = 1'b0;
        pins = 3'h5;
        ref_field_id_in = 1'b0;
        strobes = 3'h0;
        fails = 0;
        comparisons = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        // Reset contents, defaults from the rate tables, then an unmapped word
        for (int i = 0; i < 7; i++) rd(ridx[i], rexp[i], 1'b0);
        rd(10'h037, 32'h0, 1'b1);
        chk(sample_rate_sel, 3'h5);
        chk(ratio, {32'h200, 32'h200});
        chk(loop, {6'h0c, 6'h24});
        // Reserved bits written as zero read back zero; host selects the rate
        wr(acr_pkg::IDX_RATE, 32'h0000_0001);
        wr(acr_pkg::IDX_CTRL, 32'h0000_0004);
        rd(acr_pkg::IDX_RATE, 32'h1, 1'b0);
        rd(acr_pkg::IDX_CTRL, 32'h4, 1'b0);
        chk(ctrl, 16'h0004);
        tick(2);
        chk(sample_rate_sel, 3'h1);
        wr(acr_pkg::IDX_RATE, 32'h6);
        pins <= 3'h2;
        tick(8);
        chk(sample_rate_sel, 3'h6);
        wr(acr_pkg::IDX_CTRL, 32'h0);
        tick(8);
        chk(sample_rate_sel, 3'h2);
        // Loop settings kept inside the legal window by software
        wr(acr_pkg::IDX_LOOP_CAP, 32'h0b);
        wr(acr_pkg::IDX_LOOP_RES, 32'h20);
        rd(acr_pkg::IDX_LOOP_CAP, 32'h0b, 1'b0);
        rd(acr_pkg::IDX_LOOP_RES, 32'h20, 1'b0);
        chk(loop, {6'h0b, 6'h20});
        // Ratio halves staged, zero denominator skipped on the update edge
        wr(acr_pkg::IDX_NUMER_LO, 32'h1234);
        wr(acr_pkg::IDX_NUMER_HI, 32'h0056);
        wr(acr_pkg::IDX_DENOM_LO, 32'h0);
        wr(acr_pkg::IDX_DENOM_HI, 32'h0);
        rd(acr_pkg::IDX_NUMER_LO, 32'h1234, 1'b0);
        rd(acr_pkg::IDX_NUMER_HI, 32'h0056, 1'b0);
        rd(acr_pkg::IDX_DENOM_HI, 32'h0, 1'b0);
        chk(ratio, {32'h200, 32'h200});
        wr(acr_pkg::IDX_CTRL, 32'h40);
        tick(3);
        chk(ratio, {32'h0056_1234, 32'h200});
        wr(acr_pkg::IDX_DENOM_HI, 32'h1);
        wr(acr_pkg::IDX_CTRL, 32'h40);
        tick(3);
        chk(ratio, {32'h0056_1234, 32'h200});
        wr(acr_pkg::IDX_CTRL, 32'h0);
        wr(acr_pkg::IDX_CTRL, 32'h40);
        tick(3);
        chk(ratio, {32'h0056_1234, 32'h0001_0000});
        // Frame sync: host start, line end, then reference start
        wr(acr_pkg::IDX_CTRL, 32'h0);
        strobe(3'h4);
        chk(sync, 1'b1);
        strobe(3'h1);
        chk(sync, 1'b0);
        @(posedge pclk) ref_field_id_in <= 1'b1;
        tick(8);
        chk(sync, 1'b1);
        @(posedge pclk) ref_field_id_in <= 1'b0;
        strobe(3'h1);
        chk(sync, 1'b0);
        // Stretched pulse survives a line and ends at the field
        wr(acr_pkg::IDX_CTRL, 32'h2);
        strobe(3'h4);
        strobe(3'h1);
        chk(sync, 1'b1);
        strobe(3'h2);
        chk(sync, 1'b0);
        // Reference ignored; pulse free-runs on the field count
        wr(acr_pkg::IDX_CTRL, 32'h1);
        tick(8);
        @(posedge pclk) ref_field_id_in <= 1'b1;
        tick(8);
        chk(sync, 1'b0);
        strobe(3'h2);
        strobe(3'h2);
        chk(sync, 1'b0);
        strobe(3'h2);
        chk(sync, 1'b1);
        // Status: sync high, both ratios custom, pin rate 2
        rd(acr_pkg::IDX_STATUS, 32'h0000_00e2, 1'b0);
        wrap_up();
    end
endmodule // audio_clock_ratio_control_tb
